// file: hw/tcc_consts.svh
// constants of the capture, compare and single pulse timer block
//------------------------------------------------------------------
// Operation
// - active capture edge sets flag, latches counter
// - capture interrupt needs enable and clear mask
// - capture flag clears: status read, then low access
// - high byte read blocks capture until low read
// - capture register keeps most recent event only
// - capture pins always live; high read disables
// - pwm: capture one inactive; single pulse: it starts the pulse
// - compare match sets flag, drives level, interrupts
// - compare registers reset 8000h, software-only changes
// - compare pin latch low during reset
// - compare flag clears: status read, then low access
// - high byte write suspends compare until low
// - pin disabled: no level, interrupt still possible
// - divide two matches at value, else plus one
// - force bit copies level, no flag, no interrupt
// - force bits ignored in single pulse, pwm
// - single pulse select uses channel one pair
// - single pulse edge: counter FFFCh, level two, FFFDh
// - single pulse match drives level one, ends pulse
// - single pulse: no compare flag one; two flag-only
// - pwm select overrides single pulse select
// - flash variant: channel two capture, flags absent
// - counter resets FFFCh; low write reloads FFFCh
// - counter rollover to 0000h sets overflow flag
//------------------------------------------------------------------
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register byte addresses, one byte register per word
`define TCC_OFS_CTRL_TWO 8'h00
`define TCC_OFS_CTRL_ONE 8'h04
`define TCC_OFS_STATUS 8'h08
`define TCC_OFS_CAP1_HI 8'h0c
`define TCC_OFS_CAP1_LO 8'h10
`define TCC_OFS_CMP1_HI 8'h14
`define TCC_OFS_CMP1_LO 8'h18
`define TCC_OFS_CNT_HI 8'h1c
`define TCC_OFS_CNT_LO 8'h20
`define TCC_OFS_ACNT_HI 8'h24
`define TCC_OFS_ACNT_LO 8'h28
`define TCC_OFS_CAP2_HI 8'h2c
`define TCC_OFS_CAP2_LO 8'h30
`define TCC_OFS_CMP2_HI 8'h34
`define TCC_OFS_CMP2_LO 8'h38

// control one fields
`define TCC_C1_CAP_IRQ_EN 7
`define TCC_C1_CMP_IRQ_EN 6
`define TCC_C1_OVF_IRQ_EN 5
`define TCC_C1_FORCE_TWO 4
`define TCC_C1_FORCE_ONE 3
`define TCC_C1_LEVEL_TWO 2
`define TCC_C1_EDGE_ONE 1
`define TCC_C1_LEVEL_ONE 0
// control two fields
`define TCC_C2_PIN_EN_ONE 7
`define TCC_C2_PIN_EN_TWO 6
`define TCC_C2_SINGLE 5
`define TCC_C2_PWM 4
`define TCC_C2_CLK_HI 3
`define TCC_C2_CLK_LO 2
`define TCC_C2_EDGE_TWO 1
`define TCC_C2_EXT_EDGE 0

// clock select codes
`define TCC_CLK_DIV2 2'h0
`define TCC_CLK_DIV4 2'h1
`define TCC_CLK_DIV8 2'h2
`define TCC_CLK_EXT 2'h3

// values
`define TCC_CNT_RELOAD 16'hfffc
`define TCC_CNT_MAX 16'hffff
`define TCC_PULSE_CAP 16'hfffd
`define TCC_CMP_RESET 16'h8000
`define TCC_CTRL_RESET 8'h00

`endif

// file: hw/tcc_pkg.sv
// types of the capture, compare and single pulse timer block
package tcc_pkg;

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [1:0] capture_flag;
        logic [1:0] compare_flag;
        logic overflow_flag;
        logic [1:0] cap_seen;
        logic [1:0] cmp_seen;
        logic ovf_seen;
        logic [15:0] cnt;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [1:0] cap_block;
        logic [1:0] cmp_block;
        logic [7:0] lo_buf;
        logic lo_buf_vld;
        logic [2:0] pres;
        logic fresh;
        logic [1:0] cap_prev;
        logic ext_prev;
        logic [1:0] pin;
        logic irq;
        logic pready;
        logic pslverr;
        logic [7:0] rdata;
    } tcc_state_t;

endpackage

// file: hw/tcc_timer.sv
// capture, compare and single pulse timer with an apb register port
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_timer
#(
    parameter bit FLASH_VARIANT = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_pin_one,
    input wire logic capture_pin_two,
    input wire logic ext_clock_pin,
    input wire logic cpu_irq_mask,
    output logic compare_output_pin_one,
    output logic compare_output_pin_two,
    output logic compare_pin_enable_one,
    output logic compare_pin_enable_two,
    output logic timer_irq
);
    import tcc_pkg::*;

    tcc_state_t q;
    tcc_state_t n;

    //--------------------------------------------------------------
    // decoded controls
    //--------------------------------------------------------------
    logic pwm_mode;
    logic single_mode;
    logic [1:0] clk_sel;
    logic tick;
    logic ext_edge;
    logic [1:0] cap_edge;
    logic [1:0] match;
    logic div2;
    logic acc;
    logic rd;
    logic wr;
    logic mapped;
    logic [7:0] wbyte;
    logic force_one;
    logic force_two;

    assign pwm_mode = q.ctrl_two[`TCC_C2_PWM];
    assign single_mode = q.ctrl_two[`TCC_C2_SINGLE] & ~pwm_mode;
    assign clk_sel = q.ctrl_two[`TCC_C2_CLK_HI:`TCC_C2_CLK_LO];
    assign div2 = (clk_sel == `TCC_CLK_DIV2);
    assign acc = psel & penable & ~q.pready;
    assign rd = acc & ~pwrite;
    assign wr = acc & pwrite & pstrb[0];
    assign wbyte = pwdata[7:0];

    always_comb
    begin
        n = q;
        force_one = 1'b0;
        force_two = 1'b0;

        //----------------------------------------------------------
        // prescaler and counter
        //----------------------------------------------------------
        n.pres = q.pres + 3'h1;
        n.ext_prev = ext_clock_pin;
        if (q.ctrl_two[`TCC_C2_EXT_EDGE])
            ext_edge = ext_clock_pin & ~q.ext_prev;
        else
            ext_edge = ~ext_clock_pin & q.ext_prev;
        case (clk_sel)
            `TCC_CLK_DIV2: tick = (q.pres[0] == 1'b1);
            `TCC_CLK_DIV4: tick = (q.pres[1:0] == 2'h3);
            `TCC_CLK_DIV8: tick = (q.pres == 3'h7);
            default: tick = ext_edge;
        endcase
        n.fresh = tick;
        if (tick)
        begin
            n.cnt = q.cnt + 16'h0001;
        end

        // at divide by two the match shows in the first cycle of the
        // equal count; slower clocks see it as the count moves on
        for (int i = 0; i < 2; i++)
        begin
            match[i] = 1'b0;
        end
        if (div2)
        begin
            match[0] = q.fresh && (q.cnt == q.cmp1);
            match[1] = q.fresh && (q.cnt == q.cmp2);
        end
        else
        begin
            match[0] = tick && (q.cnt == q.cmp1);
            match[1] = tick && (q.cnt == q.cmp2);
        end
        match = match & ~q.cmp_block;

        //----------------------------------------------------------
        // capture edges, always watched on both pins
        //----------------------------------------------------------
        n.cap_prev = {capture_pin_two, capture_pin_one};
        if (q.ctrl_one[`TCC_C1_EDGE_ONE])
            cap_edge[0] = capture_pin_one & ~q.cap_prev[0];
        else
            cap_edge[0] = ~capture_pin_one & q.cap_prev[0];
        if (q.ctrl_two[`TCC_C2_EDGE_TWO])
            cap_edge[1] = capture_pin_two & ~q.cap_prev[1];
        else
            cap_edge[1] = ~capture_pin_two & q.cap_prev[1];

        //----------------------------------------------------------
        // register port, one wait state
        //----------------------------------------------------------
        n.pready = acc;
        n.pslverr = 1'b0;
        n.rdata = 8'h00;
        mapped = 1'b1;
        case (paddr)
            `TCC_OFS_CTRL_TWO:
            begin
                n.rdata = q.ctrl_two;
                if (wr)
                    n.ctrl_two = wbyte;
            end
            `TCC_OFS_CTRL_ONE:
            begin
                n.rdata = q.ctrl_one;
                if (wr)
                begin
                    // force bits act once and are not stored
                    n.ctrl_one = wbyte;
                    n.ctrl_one[`TCC_C1_FORCE_ONE] = 1'b0;
                    n.ctrl_one[`TCC_C1_FORCE_TWO] = 1'b0;
                    force_one = wbyte[`TCC_C1_FORCE_ONE];
                    force_two = wbyte[`TCC_C1_FORCE_TWO];
                end
            end
            `TCC_OFS_STATUS:
            begin
                n.rdata = {q.capture_flag[0], q.compare_flag[0],
                           q.overflow_flag, q.capture_flag[1],
                           q.compare_flag[1], 3'h0};
                if (rd)
                begin
                    n.cap_seen = q.cap_seen | q.capture_flag;
                    n.cmp_seen = q.cmp_seen | q.compare_flag;
                    n.ovf_seen = q.ovf_seen | q.overflow_flag;
                end
            end
            `TCC_OFS_CAP1_HI:
            begin
                n.rdata = q.cap1[15:8];
                if (rd)
                    n.cap_block[0] = 1'b1;
            end
            `TCC_OFS_CAP1_LO:
            begin
                n.rdata = q.cap1[7:0];
                if (rd)
                    n.cap_block[0] = 1'b0;
                if (acc && q.cap_seen[0])
                begin
                    n.capture_flag[0] = 1'b0;
                    n.cap_seen[0] = 1'b0;
                end
            end
            `TCC_OFS_CAP2_HI:
            begin
                n.rdata = FLASH_VARIANT ? 8'h00 : q.cap2[15:8];
                if (rd)
                    n.cap_block[1] = 1'b1;
            end
            `TCC_OFS_CAP2_LO:
            begin
                n.rdata = FLASH_VARIANT ? 8'h00 : q.cap2[7:0];
                if (rd)
                    n.cap_block[1] = 1'b0;
                if (acc && q.cap_seen[1])
                begin
                    n.capture_flag[1] = 1'b0;
                    n.cap_seen[1] = 1'b0;
                end
            end
            `TCC_OFS_CMP1_HI:
            begin
                n.rdata = q.cmp1[15:8];
                if (wr)
                begin
                    n.cmp1[15:8] = wbyte;
                    n.cmp_block[0] = 1'b1;
                end
            end
            `TCC_OFS_CMP1_LO:
            begin
                n.rdata = q.cmp1[7:0];
                if (wr)
                begin
                    n.cmp1[7:0] = wbyte;
                    n.cmp_block[0] = 1'b0;
                end
                if (acc && q.cmp_seen[0])
                begin
                    n.compare_flag[0] = 1'b0;
                    n.cmp_seen[0] = 1'b0;
                end
            end
            `TCC_OFS_CMP2_HI:
            begin
                n.rdata = FLASH_VARIANT ? 8'h00 : q.cmp2[15:8];
                if (wr)
                begin
                    n.cmp2[15:8] = wbyte;
                    n.cmp_block[1] = 1'b1;
                end
            end
            `TCC_OFS_CMP2_LO:
            begin
                n.rdata = FLASH_VARIANT ? 8'h00 : q.cmp2[7:0];
                if (wr)
                begin
                    n.cmp2[7:0] = wbyte;
                    n.cmp_block[1] = 1'b0;
                end
                if (acc && q.cmp_seen[1])
                begin
                    n.compare_flag[1] = 1'b0;
                    n.cmp_seen[1] = 1'b0;
                end
            end
            `TCC_OFS_CNT_HI, `TCC_OFS_ACNT_HI:
            begin
                // low byte frozen so a high-then-low read is coherent
                n.rdata = q.cnt[15:8];
                if (rd)
                begin
                    n.lo_buf = q.cnt[7:0];
                    n.lo_buf_vld = 1'b1;
                end
            end
            `TCC_OFS_CNT_LO, `TCC_OFS_ACNT_LO:
            begin
                n.rdata = q.lo_buf_vld ? q.lo_buf : q.cnt[7:0];
                if (rd)
                    n.lo_buf_vld = 1'b0;
                if (wr)
                    n.cnt = `TCC_CNT_RELOAD;
                // the alternate low byte leaves the overflow flag alone
                if (acc && q.ovf_seen && paddr == `TCC_OFS_CNT_LO)
                begin
                    n.overflow_flag = 1'b0;
                    n.ovf_seen = 1'b0;
                end
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
        n.pslverr = acc & ~mapped;
        if (!acc)
            n.rdata = 8'h00;

        //----------------------------------------------------------
        // hardware events, placed after the port so a set wins
        //----------------------------------------------------------
        if (tick && q.cnt == `TCC_CNT_MAX)
            n.overflow_flag = 1'b1;
        if (cap_edge[0] && !q.cap_block[0])
        begin
            if (single_mode)
            begin
                n.cnt = `TCC_CNT_RELOAD;
                n.cap1 = `TCC_PULSE_CAP;
                n.capture_flag[0] = 1'b1;
                if (q.ctrl_two[`TCC_C2_PIN_EN_ONE])
                    n.pin[0] = q.ctrl_one[`TCC_C1_LEVEL_TWO];
            end
            else if (!pwm_mode)
            begin
                n.cap1 = q.cnt;
                n.capture_flag[0] = 1'b1;
            end
        end
        if (cap_edge[1] && !q.cap_block[1] && !FLASH_VARIANT)
        begin
            n.cap2 = q.cnt;
            n.capture_flag[1] = 1'b1;
        end

        if (match[0] && !pwm_mode)
        begin
            if (!single_mode)
                n.compare_flag[0] = 1'b1;
            if (q.ctrl_two[`TCC_C2_PIN_EN_ONE])
                n.pin[0] = q.ctrl_one[`TCC_C1_LEVEL_ONE];
        end
        if (match[1] && !pwm_mode && !FLASH_VARIANT)
        begin
            n.compare_flag[1] = 1'b1;
            if (q.ctrl_two[`TCC_C2_PIN_EN_TWO] && !single_mode)
                n.pin[1] = q.ctrl_one[`TCC_C1_LEVEL_TWO];
        end

        // forced levels use the level bits just written
        if (!single_mode && !pwm_mode)
        begin
            if (force_one)
                n.pin[0] = wbyte[`TCC_C1_LEVEL_ONE];
            if (force_two)
                n.pin[1] = wbyte[`TCC_C1_LEVEL_TWO];
        end

        if (FLASH_VARIANT)
        begin
            n.capture_flag[1] = 1'b0;
            n.compare_flag[1] = 1'b0;
        end

        // one request line; a pending flag waits for enable and mask
        n.irq = ~cpu_irq_mask &
            ((q.ctrl_one[`TCC_C1_CAP_IRQ_EN] & |q.capture_flag) |
             (q.ctrl_one[`TCC_C1_CMP_IRQ_EN] & |q.compare_flag) |
             (q.ctrl_one[`TCC_C1_OVF_IRQ_EN] & q.overflow_flag));
    end

    //--------------------------------------------------------------
    // state register
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.ctrl_one <= `TCC_CTRL_RESET;
            q.ctrl_two <= `TCC_CTRL_RESET;
            q.cnt <= `TCC_CNT_RELOAD;
            q.cmp1 <= `TCC_CMP_RESET;
            q.cmp2 <= `TCC_CMP_RESET;
            q.pin <= 2'h0;
        end
        else
        begin
            q <= n;
        end
    end

    //--------------------------------------------------------------
    // outputs, all from flip-flops
    //--------------------------------------------------------------
    assign prdata = {24'h000000, q.rdata};
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign compare_output_pin_one = q.pin[0];
    assign compare_output_pin_two = q.pin[1];
    assign compare_pin_enable_one = q.ctrl_two[`TCC_C2_PIN_EN_ONE];
    assign compare_pin_enable_two = q.ctrl_two[`TCC_C2_PIN_EN_TWO];
    assign timer_irq = q.irq;

endmodule // tcc_timer
`default_nettype wire

// file: testbench/tcc_pin_model.sv
// far-side sources: capture inputs and the external count clock
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model
(
    input wire logic pclk,
    output logic cap_one,
    output logic cap_two,
    output logic ext_clk
);
    logic [1:0] cap_q = 2'b11;
    logic [2:0] div_q = 3'h0;
    // idle high, as a pulled-up floating input would sit
    assign cap_one = cap_q[0];
    assign cap_two = cap_q[1];
    assign ext_clk = div_q[2];
    // an eighth of pclk keeps well under the quarter-rate limit
    always @(posedge pclk)
        div_q <= div_q + 3'h1;
    // low then high: one falling and one rising edge per call
    task automatic pulse(input int ch);
        cap_q[ch] <= 1'b0;
        repeat (4) @(posedge pclk);
        cap_q[ch] <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask
endmodule // tcc_pin_model
`default_nettype wire

// file: testbench/tcc_timer_checker.sv
// assertions on the timer's register port, pins and interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_timer_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic capture_pin_one,
    input wire logic capture_pin_two,
    input wire logic ext_clock_pin,
    input wire logic cpu_irq_mask,
    input wire logic compare_output_pin_one,
    input wire logic compare_output_pin_two,
    input wire logic compare_pin_enable_one,
    input wire logic compare_pin_enable_two,
    input wire logic timer_irq
);
    import tcc_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic ctrl2_wr;
    assign ctrl2_wr = psel && penable && !pready && pwrite && pstrb[0]
        && paddr == `TCC_OFS_CTRL_TWO;
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    sequence s_ctrl2_write;
        s_taken ##0 ctrl2_wr;
    endsequence
    a_one_wait: assert property (s_taken |=> pready)
        else $error("no ready one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_empty: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_pin_reset: assert property (
        disable iff (1'b0) !presetn |->
        !compare_output_pin_one && !compare_output_pin_two)
        else $error("compare pin high during reset");
    a_irq_masked: assert property (cpu_irq_mask |=> !timer_irq)
        else $error("interrupt raised while masked");
    a_irq_source: assert property (
        timer_irq |-> !$past(cpu_irq_mask))
        else $error("interrupt without an open mask");
    a_en_change: assert property (
        $changed(compare_pin_enable_one) || $changed(compare_pin_enable_two)
        |-> $past(ctrl2_wr))
        else $error("pin enable moved without a control write");
    a_en_follow: assert property (
        s_ctrl2_write |=> compare_pin_enable_one == $past(pwdata[7])
        && compare_pin_enable_two == $past(pwdata[6]))
        else $error("pin enable differs from written bits");
endmodule // tcc_timer_checker
bind tcc_timer tcc_timer_checker i_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
    .ext_clock_pin(ext_clock_pin), .cpu_irq_mask(cpu_irq_mask),
    .compare_output_pin_one(compare_output_pin_one),
    .compare_output_pin_two(compare_output_pin_two),
    .compare_pin_enable_one(compare_pin_enable_one),
    .compare_pin_enable_two(compare_pin_enable_two),
    .timer_irq(timer_irq)
);
`default_nettype wire

// file: testbench/timer_capture_compare_onepulse_tb_top.sv
// self-checking bench for the capture, compare and single pulse timer
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module timer_capture_compare_onepulse_tb_top;
    import tcc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cpu_irq_mask = 1'b1, err;
    logic [7:0] paddr = 8'h00, rd;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, cap_one, cap_two, ext_clk;
    logic pin_one, pin_two, en_one, en_two, irq;
    logic [15:0] a, b, c, v;
    logic [15:0] shadow[int];
    int num_errors = 0, n_compared = 0, cyc = 0, seed = 90205;
    always #2 pclk = ~pclk;
    tcc_timer i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_pin_one(cap_one), .capture_pin_two(cap_two),
        .ext_clock_pin(ext_clk), .cpu_irq_mask(cpu_irq_mask),
        .compare_output_pin_one(pin_one), .compare_output_pin_two(pin_two),
        .compare_pin_enable_one(en_one), .compare_pin_enable_two(en_two),
        .timer_irq(irq)
    );
    tcc_pin_model i_pins
    (
        .pclk(pclk), .cap_one(cap_one), .cap_two(cap_two), .ext_clk(ext_clk)
    );
    task automatic wrap_up;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic sts;
        apb(1'b0, `TCC_OFS_STATUS, 8'h00);
    endtask
    task automatic rd16(input logic [7:0] h, output logic [15:0] r);
        apb(1'b0, h, 8'h00);
        r[15:8] = rd;
        apb(1'b0, h + 8'h04, 8'h00);
        r[7:0] = rd;
    endtask
    task automatic wr16(input logic [7:0] h, input logic [15:0] x);
        shadow[h] = x;
        apb(1'b1, h, x[15:8]);
        apb(1'b1, h + 8'h04, x[7:0]);
    endtask
    task automatic wait_pin(input logic lvl);
        int n;
        n = 0;
        do
            @(negedge pclk);
        while (pin_one !== lvl && ++n < 400);
        chk("compare pin", 16'(lvl), 16'(pin_one));
        @(posedge pclk);
    endtask
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            wrap_up;
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h3c, 8'h00);
        chk("unmapped error", 16'h0001, 16'(err));
        pstrb <= 4'he;
        apb(1'b1, `TCC_OFS_CMP1_HI, 8'h12);
        pstrb <= 4'hf;
        for (int i = 0; i < 6; i++)
        begin
            logic [7:0] h;
            h = i[0] ? `TCC_OFS_CMP2_HI : `TCC_OFS_CMP1_HI;
            if (i > 1)
                wr16(h, 16'($random(seed)));
            rd16(h, v);
            chk("compare value", (i > 1) ? shadow[h] : 16'h8000, v);
        end
        // overflow at the reset clock of pclk/2; a low write reloads
        sts;
        apb(1'b1, `TCC_OFS_CNT_LO, 8'h00);
        sts;
        chk("overflow cleared", 16'h0000, 16'(rd[5]));
        repeat (12) @(posedge pclk);
        sts;
        chk("overflow set", 16'h0001, 16'(rd[5]));
        // ---------------------------------------------------------
        // capture channel one, slow clock so counts stay readable
        // ---------------------------------------------------------
        apb(1'b1, `TCC_OFS_CTRL_TWO, 8'h08);
        apb(1'b1, `TCC_OFS_CTRL_ONE, 8'h82);
        rd16(`TCC_OFS_CNT_HI, a);
        i_pins.pulse(0);
        rd16(`TCC_OFS_CNT_HI, b);
        sts;
        chk("capture flag", 16'h0001, 16'(rd[7]));
        chk("masked irq", 16'h0000, 16'(irq));
        cpu_irq_mask <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("pending irq", 16'h0001, 16'(irq));
        @(posedge pclk);
        rd16(`TCC_OFS_CAP1_HI, c);
        chk("capture window", 16'h0001, 16'((c - a) <= (b - a)));
        sts;
        chk("flag cleared", 16'h0000, 16'(rd[7]));
        chk("irq released", 16'h0000, 16'(irq));
        apb(1'b0, `TCC_OFS_CAP1_HI, 8'h00);
        i_pins.pulse(0);
        sts;
        chk("blocked flag", 16'h0000, 16'(rd[7]));
        apb(1'b0, `TCC_OFS_CAP1_LO, 8'h00);
        chk("blocked value", {8'h00, c[7:0]}, {8'h00, rd});
        i_pins.pulse(0);
        sts;
        chk("flag again", 16'h0001, 16'(rd[7]));
        rd16(`TCC_OFS_CAP1_HI, v);
        chk("newer capture", 16'h0001, 16'(v != c));
        // ---------------------------------------------------------
        // compare channel one, then forcing on channel two
        // ---------------------------------------------------------
        apb(1'b1, `TCC_OFS_CTRL_TWO, 8'h88);
        apb(1'b1, `TCC_OFS_CTRL_ONE, 8'h41);
        sts;
        wr16(`TCC_OFS_CMP2_HI, shadow[`TCC_OFS_CMP2_HI]);
        rd16(`TCC_OFS_CNT_HI, a);
        wr16(`TCC_OFS_CMP1_HI, a + 16'd30);
        wait_pin(1'b1);
        rd16(`TCC_OFS_CNT_HI, v);
        chk("count at match", a + 16'd31, v);
        sts;
        chk("compare flag", 16'h0001, 16'(rd[6]));
        chk("compare irq", 16'h0001, 16'(irq));
        apb(1'b1, `TCC_OFS_CMP1_LO, 8'(a + 16'd30));
        sts;
        chk("compare cleared", 16'h0000, 16'(rd[6]));
        apb(1'b1, `TCC_OFS_CTRL_TWO, 8'hc8);
        apb(1'b1, `TCC_OFS_CTRL_ONE, 8'h14);
        sts;
        chk("forced pin", 16'h0001, 16'(pin_two));
        chk("no forced flag", 16'h0000, 16'(rd[3]));
        // ---------------------------------------------------------
        // single pulse: low pulse, back high as the count moves on from the compare value
        // ---------------------------------------------------------
        apb(1'b1, `TCC_OFS_CTRL_TWO, 8'ha8);
        apb(1'b1, `TCC_OFS_CTRL_ONE, 8'h0a);
        chk("force ignored", 16'h0001, 16'(pin_one));
        apb(1'b1, `TCC_OFS_CTRL_ONE, 8'h03);
        wr16(`TCC_OFS_CMP1_HI, 16'h0010);
        i_pins.pulse(0);
        chk("pulse level", 16'h0000, 16'(pin_one));
        rd16(`TCC_OFS_CAP1_HI, v);
        chk("pulse capture", 16'hfffd, v);
        wait_pin(1'b1);
        sts;
        chk("pulse compare flag", 16'h0000, 16'(rd[6]));
        chk("pulse capture flag", 16'h0001, 16'(rd[7]));
        rd16(`TCC_OFS_CAP1_HI, v);
        apb(1'b1, `TCC_OFS_CTRL_TWO, 8'hb8);
        i_pins.pulse(0);
        i_pins.pulse(1);
        sts;
        chk("capture one idle", 16'h0000, 16'(rd[7]));
        chk("capture two live", 16'h0001, 16'(rd[4]));
        presetn <= 1'b0;
        @(negedge pclk);
        chk("pin in reset", 16'h0000, 16'(pin_one));
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd16(`TCC_OFS_CMP1_HI, v);
        chk("compare after reset", 16'h8000, v);
        wrap_up;
    end
endmodule // timer_capture_compare_onepulse_tb_top
`default_nettype wire
